// File: design/elpc_defines.vh
`ifndef ELPC_DEFINES_VH
`define ELPC_DEFINES_VH
// Byte addresses on the register bus
`define ELPC_ADDR_FLAGS_1   16'hff04
`define ELPC_ADDR_FLAGS_2   16'hff05
`define ELPC_ADDR_FLAGS_3   16'hff06
`define ELPC_ADDR_BREAK_FLAG_CONTROL_REGISTER      16'hfe03
`define ELPC_ADDR_BSR       16'hfe00
`define ELPC_ADDR_CFG1      16'hff08
`define ELPC_ADDR_CTRL      16'hff0c
`define ELPC_ADDR_STATUS    16'hff10
// Field positions
`define ELPC_F1_EXT         2
`define ELPC_F1_CH0         4
`define ELPC_F1_CH1         5
`define ELPC_F1_OVF         6
`define ELPC_F2_KBD         7
`define ELPC_F3_ADC         0
`define ELPC_BREAK_FLAG_CONTROL_REGISTER_CLR_EN    7
`define ELPC_BSR_STOP_WAIT  1
`define ELPC_CFG1_SHORT_REC 7
// Vector low bytes (high byte 8'hff)
`define ELPC_VEC_RESET      8'hfe
`define ELPC_VEC_SWI        8'hfc
`define ELPC_VEC_EXT        8'hfa
`define ELPC_VEC_CH0        8'hf6
`define ELPC_VEC_CH1        8'hf4
`define ELPC_VEC_OVF        8'hf2
`define ELPC_VEC_KBD        8'he0
`define ELPC_VEC_ADC        8'hde
// Stop recovery, fast-clock cycles
`define ELPC_REC_LONG       13'd4096
`define ELPC_REC_SHORT      13'd32
// Fast clock is clk_sys divided by this plus one (enable pulse)
`define ELPC_FAST_DIV       2'd1
`endif

// File: design/elpc_core.v
// Behaviour
// [RULE_01] Latched request holds until serviced or unmasked
// [RULE_02] Entry stacks registers and sets global mask
// [RULE_03] Arbitrate only at boundary, mask and enable
// [RULE_04] Highest pending request wins at each boundary
// [RULE_05] Index-high register never stacked on entry
// [RULE_06] Software interrupt ignores global mask
// [RULE_07] Software stacks PC, hardware stacks PC-1
// [RULE_08] Fixed priority order with vector addresses
// [RULE_09] Global mask gates all but software interrupt; the code lets break bypass the mask as well
// [RULE_10] Flags register 1 read-only, fixed bits
// [RULE_11] Flags registers 2 and 3 layout
// [RULE_12] Reset highest priority, never arbitrated
// [RULE_13] Break forces fetch from software vector
// [RULE_14] Break protects flags unless clear enabled
// [RULE_15] Flag cleared in break stays cleared
// [RULE_16] Two-step clear stays protected through break
// [RULE_17] Wait or stop clears mask, halts CPU
// [RULE_18] Wait stops CPU clock only, wakes next
// [RULE_19] Break during wait sets stop/wait flag
// [RULE_20] Stop gates clocks, recovery before stacking
// [RULE_21] Short recovery 32 else 4096 fast cycles
// [RULE_22] Counter held in stop, then times recovery
// [RULE_23] Clear-enable bit read/write in control register
// [RULE_24] Recovery counter advances on fast-clock enable
// [RULE_25] Flag register writes ignored, reads harmless
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "elpc_defines.vh"
module elpc_core (
  clk_sys,
  rst_n,
  haddr,
  htrans,
  hwrite,
  hsize,
  hsel,
  hready,
  hwdata,
  hrdata,
  hreadyout,
  hresp,
  irq_ext,
  irq_ch0,
  irq_ch1,
  irq_ovf,
  irq_kbd,
  irq_adc,
  en_ext,
  en_ch0,
  en_ch1,
  en_ovf,
  en_kbd,
  en_adc,
  sys_reset_req,
  brk_req,
  insn_done,
  insn_swi,
  insn_rti,
  insn_wait,
  insn_stop,
  clr_mask,
  stack_done,
  pc_cur,
  vec_valid,
  vec_addr,
  stack_pc,
  stack_index_hi,
  set_mask,
  cpu_clk_en,
  osc_clk_en,
  periph_clk_en,
  in_break,
  flag_clr_allow
);
  input  wire        clk_sys;
  input  wire        rst_n;
  input  wire [31:0] haddr;
  input  wire [1:0]  htrans;
  input  wire        hwrite;
  input  wire [2:0]  hsize;
  input  wire        hsel;
  input  wire        hready;
  input  wire [31:0] hwdata;
  output reg  [31:0] hrdata;
  output reg         hreadyout;
  output reg         hresp;
  input  wire        irq_ext;
  input  wire        irq_ch0;
  input  wire        irq_ch1;
  input  wire        irq_ovf;
  input  wire        irq_kbd;
  input  wire        irq_adc;
  input  wire        en_ext;
  input  wire        en_ch0;
  input  wire        en_ch1;
  input  wire        en_ovf;
  input  wire        en_kbd;
  input  wire        en_adc;
  input  wire        sys_reset_req;
  input  wire        brk_req;
  input  wire        insn_done;
  input  wire        insn_swi;
  input  wire        insn_rti;
  input  wire        insn_wait;
  input  wire        insn_stop;
  input  wire        clr_mask;
  input  wire        stack_done;
  input  wire [15:0] pc_cur;
  output reg         vec_valid;
  output reg  [15:0] vec_addr;
  output reg  [15:0] stack_pc;
  output reg         stack_index_hi;
  output reg         set_mask;
  output reg         cpu_clk_en;
  output reg         osc_clk_en;
  output reg         periph_clk_en;
  output reg         in_break;
  output reg         flag_clr_allow;

  localparam ST_RUN  = 3'd0;
  localparam ST_WAIT = 3'd1;
  localparam ST_STOP = 3'd2;
  localparam ST_REC  = 3'd3;
  localparam ST_SVC  = 3'd4;

  reg [2:0]  state_q;
  reg        imask_q;
  reg        latched_q;
  reg [7:0]  vec_lo_q;
  reg        break_flag_clear_enable_q;
  reg        break_stop_wait_flag_q;
  reg        short_stop_recovery_q;
  reg [12:0] rec_cnt_q;
  reg [1:0]  div_q;
  reg        fast_en_q;
  reg        wr_q;
  reg [15:0] wa_q;
  reg        swi_pend_q;

  wire [5:0] hw_req;
  wire       any_hw;
  wire       ap_valid;
  reg  [7:0] pick_lo;
  reg  [7:0] rd_val;
  reg [12:0] rec_lim;

  // Enabled hardware requests, gated by global mask
  assign hw_req = {irq_ext & en_ext, irq_ch0 & en_ch0, irq_ch1 & en_ch1,
                   irq_ovf & en_ovf, irq_kbd & en_kbd,
                   irq_adc & en_adc} & {6{~imask_q}}; // [RULE_03] [RULE_09]
  assign any_hw = |hw_req;
  assign ap_valid = hsel & hready & htrans[1];

  // Fixed priority pick
  always @* begin
    if (hw_req[5])
      pick_lo = `ELPC_VEC_EXT; // [RULE_08] [RULE_04]
    else if (hw_req[4])
      pick_lo = `ELPC_VEC_CH0;
    else if (hw_req[3])
      pick_lo = `ELPC_VEC_CH1;
    else if (hw_req[2])
      pick_lo = `ELPC_VEC_OVF;
    else if (hw_req[1])
      pick_lo = `ELPC_VEC_KBD;
    else
      pick_lo = `ELPC_VEC_ADC;
  end

  always @* begin
    if (short_stop_recovery_q)
      rec_lim = `ELPC_REC_SHORT; // [RULE_21]
    else
      rec_lim = `ELPC_REC_LONG;
  end

  // Register read mux
  always @* begin
    rd_val = 8'h00;
    case (haddr[15:0])
      `ELPC_ADDR_FLAGS_1: begin
        rd_val[`ELPC_F1_EXT] = irq_ext; // [RULE_10] [RULE_25]
        rd_val[`ELPC_F1_CH0] = irq_ch0;
        rd_val[`ELPC_F1_CH1] = irq_ch1;
        rd_val[`ELPC_F1_OVF] = irq_ovf;
      end
      `ELPC_ADDR_FLAGS_2: rd_val[`ELPC_F2_KBD] = irq_kbd; // [RULE_11]
      `ELPC_ADDR_FLAGS_3: rd_val[`ELPC_F3_ADC] = irq_adc; // [RULE_11]
      `ELPC_ADDR_BREAK_FLAG_CONTROL_REGISTER:    rd_val[`ELPC_BREAK_FLAG_CONTROL_REGISTER_CLR_EN] = break_flag_clear_enable_q;
      `ELPC_ADDR_BSR:     rd_val[`ELPC_BSR_STOP_WAIT] = break_stop_wait_flag_q;
      `ELPC_ADDR_CFG1:    rd_val[`ELPC_CFG1_SHORT_REC] = short_stop_recovery_q;
      `ELPC_ADDR_CTRL:    rd_val = {5'h00, in_break, latched_q, imask_q};
      `ELPC_ADDR_STATUS:  rd_val = {5'h00, state_q};
      default:            rd_val = 8'h00;
    endcase
  end

  // Bus slave: zero wait states
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_q      <= 1'b0;
      wa_q      <= 16'h0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      break_flag_clear_enable_q    <= 1'b0;
      short_stop_recovery_q   <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (ap_valid) begin
        wr_q <= hwrite;
        wa_q <= haddr[15:0];
      end else begin
        wr_q <= 1'b0;
      end
      if (wr_q) begin
        if (wa_q == `ELPC_ADDR_BREAK_FLAG_CONTROL_REGISTER)
          break_flag_clear_enable_q <= hwdata[`ELPC_BREAK_FLAG_CONTROL_REGISTER_CLR_EN]; // [RULE_23]
        if (wa_q == `ELPC_ADDR_CFG1)
          short_stop_recovery_q <= hwdata[`ELPC_CFG1_SHORT_REC];
      end
    end
  end

  // Read data registered in address phase
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      hrdata <= 32'h00000000;
    else if (ap_valid && !hwrite)
      hrdata <= {24'h000000, rd_val};
  end

  // Fast clock enable divider
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q     <= 2'd0;
      fast_en_q <= 1'b0;
    end else begin
      fast_en_q <= (div_q == `ELPC_FAST_DIV);
      if (div_q == `ELPC_FAST_DIV)
        div_q <= 2'd0;
      else
        div_q <= div_q + 2'd1;
    end
  end

  // Exception sequencer
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q        <= ST_RUN;
      imask_q        <= 1'b1;
      latched_q      <= 1'b0;
      vec_lo_q       <= `ELPC_VEC_RESET;
      rec_cnt_q      <= 13'd0;
      break_stop_wait_flag_q         <= 1'b0;
      swi_pend_q     <= 1'b0;
      vec_valid      <= 1'b0;
      vec_addr       <= 16'hfffe;
      stack_pc       <= 16'h0000;
      stack_index_hi <= 1'b0;
      set_mask       <= 1'b0;
      cpu_clk_en     <= 1'b1;
      osc_clk_en     <= 1'b1;
      periph_clk_en  <= 1'b1;
      in_break       <= 1'b0;
      flag_clr_allow <= 1'b1;
    end else begin
      set_mask       <= 1'b0;
      stack_index_hi <= 1'b0; // [RULE_05]
      flag_clr_allow <= ~in_break | break_flag_clear_enable_q; // [RULE_14] [RULE_15] [RULE_16]
      if (clr_mask) begin
        imask_q   <= 1'b0;
        latched_q <= 1'b0; // [RULE_01]
      end
      if (sys_reset_req) begin
        state_q    <= ST_SVC; // [RULE_12]
        vec_lo_q   <= `ELPC_VEC_RESET;
        latched_q  <= 1'b1;
        imask_q    <= 1'b1;
        vec_valid  <= 1'b1;
        vec_addr   <= {8'hff, `ELPC_VEC_RESET};
        cpu_clk_en <= 1'b1;
        osc_clk_en <= 1'b1;
        periph_clk_en <= 1'b1;
        in_break   <= 1'b0;
      end else begin
        case (state_q)
          ST_RUN: begin
            if (insn_rti)
              in_break <= 1'b0;
            if (brk_req) begin
              state_q  <= ST_SVC; // [RULE_13]
              vec_lo_q <= `ELPC_VEC_SWI;
              in_break <= 1'b1;
              latched_q <= 1'b1;
              stack_pc <= pc_cur - 16'd1;
            end else if (insn_done && insn_swi) begin
              state_q  <= ST_SVC; // [RULE_06]
              vec_lo_q <= `ELPC_VEC_SWI;
              latched_q <= 1'b1;
              stack_pc <= pc_cur; // [RULE_07]
            end else if (insn_done && insn_wait) begin
              state_q    <= ST_WAIT; // [RULE_17] [RULE_18]
              imask_q    <= 1'b0;
              cpu_clk_en <= 1'b0;
            end else if (insn_done && insn_stop) begin
              state_q       <= ST_STOP; // [RULE_17] [RULE_20]
              imask_q       <= 1'b0;
              cpu_clk_en    <= 1'b0;
              osc_clk_en    <= 1'b0;
              periph_clk_en <= 1'b0;
              rec_cnt_q     <= 13'd0; // [RULE_22]
            end else if (insn_done && any_hw && !latched_q) begin
              state_q   <= ST_SVC; // [RULE_03] [RULE_04]
              vec_lo_q  <= pick_lo;
              latched_q <= 1'b1; // [RULE_01]
              stack_pc  <= pc_cur - 16'd1; // [RULE_07]
            end
          end
          ST_WAIT: begin
            if (brk_req) begin
              break_stop_wait_flag_q     <= 1'b1; // [RULE_19]
              in_break   <= 1'b1;
              vec_lo_q   <= `ELPC_VEC_SWI;
              state_q    <= ST_SVC;
              latched_q  <= 1'b1;
              cpu_clk_en <= 1'b1;
              stack_pc   <= pc_cur - 16'd1;
            end else if (any_hw) begin
              vec_lo_q   <= pick_lo; // [RULE_18]
              state_q    <= ST_SVC;
              latched_q  <= 1'b1;
              cpu_clk_en <= 1'b1;
              stack_pc   <= pc_cur - 16'd1;
            end
          end
          ST_STOP: begin
            rec_cnt_q <= 13'd0; // [RULE_22]
            if (brk_req || any_hw) begin
              state_q    <= ST_REC; // [RULE_20]
              osc_clk_en <= 1'b1;
              in_break   <= brk_req;
              vec_lo_q   <= brk_req ? `ELPC_VEC_SWI : pick_lo;
              latched_q  <= 1'b1;
              stack_pc   <= pc_cur - 16'd1;
            end
          end
          ST_REC: begin
            if (fast_en_q)
              rec_cnt_q <= rec_cnt_q + 13'd1; // [RULE_24] [RULE_22]
            if (rec_cnt_q == rec_lim) begin
              state_q       <= ST_SVC; // [RULE_20] [RULE_21]
              cpu_clk_en    <= 1'b1;
              periph_clk_en <= 1'b1;
            end
          end
          ST_SVC: begin
            vec_valid <= 1'b1;
            vec_addr  <= {8'hff, vec_lo_q}; // [RULE_08]
            if (stack_done) begin
              state_q   <= ST_RUN; // [RULE_02]
              imask_q   <= 1'b1;
              set_mask  <= 1'b1;
              latched_q <= 1'b0;
              vec_valid <= 1'b0;
            end
          end
          default: state_q <= ST_RUN;
        endcase
      end
      if (wr_q && wa_q == `ELPC_ADDR_BSR && !hwdata[`ELPC_BSR_STOP_WAIT]
          && !(state_q == ST_WAIT && brk_req))
        break_stop_wait_flag_q <= 1'b0;
    end
  end
endmodule

// File: verif/elpc_core_monitor.sv
`timescale 1ns/1ps
module elpc_core_monitor (
  input wire        clk_sys,
  input wire        rst_n,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hsel,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        brk_req,
  input wire        insn_done,
  input wire        insn_swi,
  input wire        insn_wait,
  input wire        insn_stop,
  input wire        stack_done,
  input wire [15:0] pc_cur,
  input wire        vec_valid,
  input wire [15:0] vec_addr,
  input wire [15:0] stack_pc,
  input wire        stack_index_hi,
  input wire        set_mask,
  input wire        cpu_clk_en,
  input wire        osc_clk_en,
  input wire        periph_clk_en,
  input wire        sys_reset_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_swi;
    insn_done && insn_swi && !vec_valid && !brk_req && cpu_clk_en;
  endsequence
  sequence s_ack;
    vec_valid && stack_done;
  endsequence
  sequence s_rd1;
    hsel && htrans[1] && !hwrite && haddr == 32'h0000ff04;
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  chk_idx_unstacked: assert property (vec_valid |-> !stack_index_hi)
    else $error("index high stacked");
  chk_swi_vector: assert property (s_swi |-> ##[1:2]
    (vec_valid && vec_addr == 16'hfffc && stack_pc == pc_cur))
    else $error("software interrupt entry wrong");
  chk_vec_hold: assert property (vec_valid && !stack_done && !sys_reset_req
    |=> vec_valid && $stable(vec_addr))
    else $error("vector changed before stacking done");
  chk_entry_mask: assert property (s_ack |=> set_mask && !vec_valid)
    else $error("mask not set on entry");
  chk_wait_clocks: assert property (insn_done && insn_wait && !vec_valid
    |-> ##[1:2] (!cpu_clk_en && periph_clk_en))
    else $error("wait clocks wrong");
  chk_stop_clocks: assert property (insn_done && insn_stop && !vec_valid
    |-> ##[1:2] !osc_clk_en)
    else $error("stop did not gate clocks");
  chk_brk_vector: assert property (brk_req && cpu_clk_en && osc_clk_en &&
    !vec_valid |-> ##[1:2] (vec_valid && vec_addr == 16'hfffc))
    else $error("break vector wrong");
  chk_flag1_zeros: assert property (s_rd1 |=> hrdata[31:7] == 25'h0 &&
    !hrdata[3] && hrdata[1:0] == 2'h0)
    else $error("fixed flag bits not zero");
endmodule

// File: verif/elpc_cpu_model.sv
`timescale 1ns/1ps
module elpc_cpu_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic vec_valid,
  input  wire logic slow,
  output logic      stack_done
);
  int cnt;
  // Stacks and fetches the vector, then acknowledges once
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      stack_done <= 1'b0;
    end else if (vec_valid && !stack_done) begin
      cnt <= cnt + 1;
      if (cnt == (slow ? 9 : 2)) begin
        stack_done <= 1'b1;
      end
    end else begin
      cnt <= 0;
      stack_done <= 1'b0;
    end
  end
endmodule

// File: verif/tb_elpc_core.sv
`timescale 1ns/1ps
`include "elpc_defines.vh"
module tb_elpc_core;
  logic clk_sys = 0, rst_n = 0, hwrite = 0, hsel = 0, slow = 0;
  logic [31:0] haddr = 0, hwdata = 0, d;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] pc_cur = 0;
  logic irq_ext = 0, irq_ch0 = 0, irq_ch1 = 0, irq_ovf = 0, irq_kbd = 0;
  logic irq_adc = 0, en_ext = 0, en_ch0 = 0, en_ch1 = 0, en_ovf = 0;
  logic en_kbd = 0, en_adc = 0, sys_reset_req = 0, brk_req = 0;
  logic insn_done = 0, insn_swi = 0, insn_rti = 0, insn_wait = 0;
  logic insn_stop = 0, clr_mask = 0;
  wire [31:0] hrdata;
  wire [15:0] vec_addr, stack_pc;
  wire hreadyout, hresp, vec_valid, stack_index_hi, set_mask, cpu_clk_en;
  wire osc_clk_en, periph_clk_en, in_break, flag_clr_allow, stack_done;
  wire hready;
  assign hready = hreadyout;
  int n_mismatch = 0, compares = 0, n;
  logic [5:0] r;
  logic [7:0] lo [6] = '{`ELPC_VEC_EXT, `ELPC_VEC_CH0, `ELPC_VEC_CH1,
    `ELPC_VEC_OVF, `ELPC_VEC_KBD, `ELPC_VEC_ADC};
  elpc_core u_elpc_core (.*);
  elpc_cpu_model u_elpc_cpu_model (.*);
  always #50 clk_sys = ~clk_sys;
  task tally_and_finish;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task rdy;
    int k;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (hreadyout !== 1'b1 && k < 99);
    if (k >= 99) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  task bus(input logic w, input logic [31:0] a, wd);
    @(posedge clk_sys);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    rdy();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= wd;
    rdy();
    d = hrdata;
  endtask
  task rd(input logic [31:0] a, e, input string nm);
    bus(0, a, 0);
    chk(nm, e, d);
  endtask
  task ins(input logic s, wt, st);
    @(posedge clk_sys);
    {insn_done, insn_swi, insn_wait, insn_stop} <= {1'b1, s, wt, st};
    @(posedge clk_sys);
    {insn_done, insn_swi, insn_wait, insn_stop} <= 4'h0;
  endtask
  task pls(input int k);
    @(posedge clk_sys);
    {brk_req, insn_rti, clr_mask} <= 3'h1 << k;
    @(posedge clk_sys);
    {brk_req, insn_rti, clr_mask} <= 3'h0;
  endtask
  task req(input logic [5:0] v);
    @(posedge clk_sys);
    {irq_adc, irq_kbd, irq_ovf, irq_ch1, irq_ch0, irq_ext} <= v;
    {en_adc, en_kbd, en_ovf, en_ch1, en_ch0, en_ext} <= v;
  endtask
  task wv(input logic lv);
    n = 0;
    while (vec_valid !== lv && n < 9000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 9000) begin
      n_mismatch++;
      tally_and_finish;
    end
  endtask
  function automatic logic [15:0] ev(input logic [5:0] v);
    ev = 16'h0;
    for (int i = 5; i >= 0; i--) if (v[i]) ev = {8'hff, lo[i]};
  endfunction
  task svc(input logic [5:0] v);
    pc_cur <= 16'($urandom);
    slow <= 1'($urandom);
    req(v);
    pls(0);
    ins(0, 0, 0);
    wv(1);
    chk("vector", ev(v), vec_addr);
    chk("stacked pc", 16'(pc_cur - 16'h1), stack_pc);
    req(0);
    wv(0);
  endtask
  initial begin
    void'($urandom(41697));
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    repeat (6) begin
      r = 6'($urandom);
      req(r);
      rd(32'hff04, {r[3:1], 1'b0, r[0], 2'h0}, "flags1");
      rd(32'hff05, {r[4], 7'h0}, "flags2");
      rd(32'hff06, r[5], "flags3");
    end
    bus(1, 32'hff04, 32'hff);
    rd(32'hff04, {r[3:1], 1'b0, r[0], 2'h0}, "flags1 wr");
    rd(32'hff20, 0, "unmapped");
    bus(1, 32'hfe03, 32'h80);
    rd(32'hfe03, 32'h80, "clear enable");
    bus(1, 32'hfe03, 32'h0);
    req(0);
    pc_cur <= 16'h1234;
    ins(1, 0, 0);
    wv(1);
    chk("swi stacked pc", 16'h1234, stack_pc);
    wv(0);
    req(6'h1);
    ins(0, 0, 0);
    repeat (4) @(posedge clk_sys);
    chk("masked", 0, vec_valid);
    svc(6'h1);
    svc(6'h3f);
    repeat (8) svc(6'h1 | 6'($urandom));
    ins(0, 1, 0);
    repeat (3) @(posedge clk_sys);
    chk("wait clocks", 1, {cpu_clk_en, periph_clk_en});
    req(6'h10);
    wv(1);
    chk("wake vector", ev(6'h10), vec_addr);
    req(0);
    wv(0);
    for (int k = 0; k < 2; k++) begin
      bus(1, 32'hff08, k ? 32'h0 : 32'h80);
      rd(32'hff08, k ? 32'h0 : 32'h80, "short recovery");
      ins(0, 0, 1);
      repeat (3) @(posedge clk_sys);
      chk("osc gated", 0, osc_clk_en);
      req(6'h20);
      wv(1);
      chk("recovery", 1, k ? n inside {[8192:8200]} : n inside {[64:72]});
      req(0);
      wv(0);
    end
    req(6'h1);
    pls(0);
    @(posedge clk_sys);
    {sys_reset_req, insn_done} <= 2'h3;
    @(posedge clk_sys);
    {sys_reset_req, insn_done} <= 2'h0;
    wv(1);
    chk("reset vec", 16'hfffe, vec_addr);
    req(0);
    wv(0);
    pls(2);
    wv(1);
    chk("break vec", 16'hfffc, vec_addr);
    chk("break state", 2'h2, {in_break, flag_clr_allow});
    bus(1, 32'hfe03, 32'h80);
    repeat (2) @(posedge clk_sys);
    chk("clear allowed", 1, flag_clr_allow);
    wv(0);
    pls(1);
    ins(0, 1, 0);
    pls(2);
    wv(1);
    bus(0, 32'hfe00, 0);
    chk("stop wait flag", 1, d[1]);
    wv(0);
    bus(1, 32'hfe00, 32'h0);
    rd(32'hfe00, 32'h0, "stop wait clear");
    pls(1);
    tally_and_finish;
  end
endmodule
bind elpc_core elpc_core_monitor u_elpc_core_monitor (.*);
